// File: rtl/spfec_port_fail_capture.v
// Behaviour
// - Stop-on-fail clear: keep transmitting after failure
// - Stop-on-fail set: flag port error, stop sending
// - Drop-on-fail clear: retry refused packets
// - Drop-on-fail set: discard refused packets past threshold; endpoints (SWITCH_DEVICE 0) retry instead
// - Below threshold again: stop discarding, resume
// - Isolation clear: port may issue packets
// - Isolation set: no packets issued or accepted
// - Isolated: training and link-requests still work
// - Isolated: refuse every received packet
// - Port control bit 0 reads constant 1
// - Header upper half reads 0000h
// - Header lower half reads 0007h
// - Bit 31 set on direct-IO error reply
// - Bit 30 set on message error reply
// - Bits 29 and 26 read zero
// - Bit 28 set on bad message payload
// - Bit 27 set on illegal response fields
// - Bit 27 set on illegal request fields
// - Captured bits stay until written zero
`include "spfec_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module spfec_port_fail_capture #(
	parameter SWITCH_DEVICE = 1
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [15:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output wire        wb_err_o,
	input  wire        outputFailed,
	input  wire        overFailThreshold,
	input  wire        txPktPending,
	input  wire        txPktRefused,
	output wire        txSendEn,
	output wire        txDiscard,
	output wire        txRetry,
	output reg         portErrorSet,
	input  wire        rxPktValid,
	output wire        rxPktAccept,
	output wire        rxPktNotAccepted,
	output wire        linkCtrlSymEn,
	input  wire        ioErrorReply,
	input  wire        messageErrorReply,
	input  wire        badMessagePayload,
	input  wire        illegalRespFields,
	input  wire        illegalReqFields
);
	reg  [2:0]  portCtrl_r;
	reg  [3:0]  errCapt_r;
	wire        stopOnFailEn = portCtrl_r[2];
	wire        dropOnFailEn = portCtrl_r[1];
	wire        isolated     = portCtrl_r[0];
	wire        req          = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wrReq        = req & wb_we_i;
	// Upper address bits must be zero, else 0x5000 would alias onto 0x1000
	wire        adrHigh      = |wb_adr_i[15:14];
	wire [13:0] adr          = {wb_adr_i[13:2], 2'b00};
	wire        hitCtrl      = ~adrHigh & (adr == `SPFEC_OFF_PORT_CTRL);
	wire        hitHdr       = ~adrHigh & (adr == `SPFEC_OFF_BLOCK_HDR);
	wire        hitCapt      = ~adrHigh & (adr == `SPFEC_OFF_ERR_CAPT);
	wire        mapped       = hitCtrl | hitHdr | hitCapt;
	wire        stopped      = stopOnFailEn & outputFailed;
	// Dropping only on switches; endpoints keep retrying
	wire        dropNow      = (SWITCH_DEVICE != 0) & dropOnFailEn & overFailThreshold;
	wire [3:0]  captSet;
	wire [3:0]  captKeep;
	wire [31:0] ctrlView;
	wire [31:0] captView;

	assign wb_err_o = 1'b0;
	// Failure alone does not stop sending unless stop-on-fail is on
	assign txSendEn  = ~isolated & ~stopped & txPktPending;
	// Discard tracks the live threshold, so healing ends discarding; retry resumes unless stopped
	assign txDiscard = txPktPending & ~isolated & (stopped | txPktRefused) & dropNow;
	assign txRetry   = txPktRefused & ~dropNow & ~isolated & ~stopped;
	assign rxPktAccept      = rxPktValid & ~isolated;
	assign rxPktNotAccepted = rxPktValid & isolated;
	// Control symbols never gated by isolation
	assign linkCtrlSymEn = 1'b1;

	assign captSet = {ioErrorReply, messageErrorReply, badMessagePayload,
		illegalRespFields | illegalReqFields};
	// Only a zero written clears; ones keep the flag
	assign captKeep = 4'hf;
	assign ctrlView = {28'h0000000, stopOnFailEn, dropOnFailEn, isolated, 1'b1};
	assign captView = {errCapt_r[3], errCapt_r[2], 1'b0, errCapt_r[1], errCapt_r[0],
		1'b0, 26'h0000000};

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			portCtrl_r   <= `SPFEC_CTRL_RESET;
			errCapt_r    <= 4'h0;
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= 32'h00000000;
			portErrorSet <= 1'b0;
		end else begin
			wb_ack_o     <= req;
			portErrorSet <= stopped;
			if (wrReq && hitCtrl && wb_sel_i[0]) begin
				portCtrl_r <= wb_dat_i[3:1];
			end
			// Set beats clear in the same cycle
			if (wrReq && hitCapt && wb_sel_i[3]) begin
				errCapt_r <= captSet | (errCapt_r & {wb_dat_i[31], wb_dat_i[30],
					wb_dat_i[28], wb_dat_i[27]} & captKeep);
			end else begin
				errCapt_r <= errCapt_r | captSet;
			end
			if (req && !wb_we_i) begin
				if (hitCtrl) begin
					wb_dat_o <= ctrlView;
				end else if (hitHdr) begin
					wb_dat_o <= {`SPFEC_NEXT_PTR, `SPFEC_FEATURE_ID};
				end else if (hitCapt) begin
					wb_dat_o <= captView;
				end else begin
					wb_dat_o <= 32'h00000000;
				end
			end
		end
	end
endmodule // spfec_port_fail_capture
`default_nettype wire

// File: rtl/spfec_defines.vh
`ifndef SPFEC_DEFINES_VH
`define SPFEC_DEFINES_VH
`define SPFEC_ADDR_W          14
`define SPFEC_OFF_PORT_CTRL   14'h1000
`define SPFEC_OFF_BLOCK_HDR   14'h2000
`define SPFEC_OFF_ERR_CAPT    14'h2008
`define SPFEC_OFF_FAIL_CTRL   14'h1004
`define SPFEC_BIT_STOP_FAIL   3
`define SPFEC_BIT_DROP_FAIL   2
`define SPFEC_BIT_ISOLATE     1
`define SPFEC_BIT_PORT_TYPE   0
`define SPFEC_BIT_IO_ERR      31
`define SPFEC_BIT_MSG_ERR     30
`define SPFEC_BIT_BAD_MSG     28
`define SPFEC_BIT_ILLEGAL     27
`define SPFEC_NEXT_PTR        16'h0000
`define SPFEC_FEATURE_ID      16'h0007
`define SPFEC_CTRL_RESET      3'h0
`endif

// File: tb/spfec_chk.sv
`timescale 1ns/10ps
`default_nettype none
module spfec_chk(input wire logic clk, rst, wb_cyc_i, wb_stb_i, wb_ack_o, outputFailed,
	txSendEn, txRetry, portErrorSet, rxPktValid, rxPktAccept, rxPktNotAccepted, linkCtrlSymEn);
default clocking @(posedge clk); endclocking
default disable iff (rst);
ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
stop_send_a:
	assert property (portErrorSet && outputFailed |-> !txSendEn) else $error("sent after fail");
error_cause_a:
	assert property ($rose(portErrorSet) |-> $past(outputFailed)) else $error("port error");
rx_answer_a:
	assert property (rxPktValid |-> rxPktAccept ^ rxPktNotAccepted) else $error("rx answer");
rx_idle_a: assert property (!rxPktValid |-> !(rxPktAccept || rxPktNotAccepted)) else $error("rx idle");
isolate_tx_a:
	assert property (rxPktNotAccepted |-> !txSendEn && !txRetry) else $error("isolated tx");
link_sym_a:
	assert property (linkCtrlSymEn) else $error("link symbols off");
endmodule // spfec_chk
bind spfec_port_fail_capture spfec_chk spfec_chk_i(.*);
`default_nettype wire

// File: tb/spfec_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module spfec_link_partner(input wire logic clk, rst, trafficOn, output logic txPktPending, rxPktValid);
	// One packet each way every cycle while traffic runs
	always_ff @(posedge clk or posedge rst)
		if (rst) {txPktPending, rxPktValid} <= 2'h0;
		else {txPktPending, rxPktValid} <= {2{trafficOn}};
endmodule // spfec_link_partner
`default_nettype wire

// File: tb/serial_port_fail_and_error_capture_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serial_port_fail_and_error_capture_tb_top;
logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, trafficOn = 0, outputFailed = 0;
logic overFailThreshold = 0, txPktRefused = 0, ioErrorReply = 0, messageErrorReply = 0;
logic badMessagePayload = 0, illegalRespFields = 0, illegalReqFields = 0;
logic [15:0] wb_adr_i = 16'h0;
logic [31:0] wb_dat_i = 32'h0, got;
logic [31:0] evBit[5] = '{32'h80000000, 32'h40000000, 32'h10000000, 32'h08000000, 32'h08000000};
wire [31:0] wb_dat_o;
wire wb_ack_o, txSendEn, txDiscard, txRetry, portErrorSet, txPktPending, rxPktValid;
wire rxPktAccept, rxPktNotAccepted, linkCtrlSymEn;
int errors = 0, total_checks = 0;
always #25 clk = ~clk;
spfec_link_partner spfec_link_partner_i(.*);
spfec_port_fail_capture spfec_port_fail_capture_i(.*, .wb_sel_i(4'hf), .wb_err_o());
task automatic ck(string n, logic [31:0] s, e);
	total_checks++;
	if (s !== e) begin errors++; $display("CHECK FAILED %s expected %h seen %h", n, e, s); end
endtask
task automatic bus(logic w, logic [15:0] a, logic [31:0] d);
	int i = 0;
	@(posedge clk) {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
	do @(posedge clk); while (!wb_ack_o && ++i < 20);
	got = wb_dat_o;
	{wb_cyc_i, wb_stb_i} <= 2'h0;
	if (i >= 20) begin errors++; tally_and_finish; end
endtask
task tally_and_finish;
	$display("checks %0d mismatches %0d", total_checks, errors);
	if (errors == 0 && total_checks > 0) $display("verification passed");
	else $display("verification failed");
	$finish;
endtask
initial begin
	repeat (20) @(posedge clk);
	rst <= 0;
	bus(0, 16'h2000, 32'h0); ck("header", got, 32'h00000007);
	bus(0, 16'h1000, 32'h0); ck("control", got, 32'h00000001);
	bus(0, 16'h3000, 32'h0); ck("unmapped", got, 32'h0);
	bus(1, 16'h1000, 32'hc);
	{trafficOn, outputFailed, overFailThreshold, txPktRefused} <= 4'hf;
	repeat (2) @(negedge clk);
	ck("send error drop", {txSendEn, portErrorSet, txDiscard}, 32'h3);
	@(posedge clk) overFailThreshold <= 0;
	@(negedge clk) ck("healed", txDiscard, 32'h0);
	bus(1, 16'h1000, 32'h2);
	@(negedge clk) ck("isolated", {txSendEn, rxPktNotAccepted, rxPktAccept, linkCtrlSymEn}, 32'h5);
	bus(1, 16'h1000, 32'h0);
	@(negedge clk) ck("open", {txSendEn, txRetry, rxPktAccept, rxPktNotAccepted}, 32'he);
	$display("port control test done");
	for (int k = 0; k < 5; k++) begin
		@(posedge clk) {ioErrorReply, messageErrorReply, badMessagePayload, illegalRespFields, illegalReqFields} <= 5'h10 >> k;
		@(posedge clk) {ioErrorReply, messageErrorReply, badMessagePayload, illegalRespFields, illegalReqFields} <= 5'h0;
		bus(1, 16'h2008, 32'hffffffff); bus(0, 16'h2008, 32'h0); ck("capture", got, evBit[k]);
		bus(1, 16'h2008, 32'h0); bus(0, 16'h2008, 32'h0); ck("cleared", got, 32'h0);
	end
	$display("capture test done");
	tally_and_finish;
end
endmodule // serial_port_fail_and_error_capture_tb_top
`default_nettype wire
